// ---- otp_rom_program_sequencer.sv ----
// external programmer for a byte-wide otp rom: program, verify, final read, identification
// assumes pin inputs synchronous to clk_sys; supplies switched by external regulators
// What this block does
// - each program strobe pulse is held low for 100 us, never under 95 nor over 105 us.
// - programming begins with the first address presented before any pulse.
// - core supply is raised to 6.5 V and programming supply to 13.0 V before pulsing.
// - the first pass gives every address exactly one pulse with no read-back.
// - a second loop then reads back every address and reprograms only a mismatching byte.
// - a mismatching byte gets up to 10 further pulses, each followed by a read-back.
// - a byte still wrong after 10 retry pulses stops the run and fails the device.
// - a byte that verifies moves the loop to the next address until all are checked.
// - after the verify loop both supplies go back to 5.0 V.
// - at normal supply every byte is read again and pass is given only if all match.
// - identification mode is entered by holding the id address line at the id voltage.
// - reads wait the data valid delay after enable and the float delay after release.
// - core supply goes up no later and down no earlier than the programming supply.
`timescale 1ns/10ps
`include "otp_prog_regs.svh"
module otp_rom_program_sequencer #(
    parameter int PULSE_CYCLES = `PW_NOM_NS / `CLK_PERIOD_NS,
    parameter int ADDR_W       = `ADDR_W
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // user commands
    input  wire logic              start,
    input  wire logic              id_start,
    input  wire logic              id_sel,
    // source image, looked up at rom_addr
    input  wire logic [7:0]        src_data,
    // status
    output logic                   busy,
    output logic                   done,
    output logic                   pass,
    output logic                   fail,
    output logic [ADDR_W-1:0]      fail_addr,
    output logic [7:0]             id_code,
    output logic                   id_valid,
    // rom pins
    output logic [ADDR_W-1:0]      rom_addr,
    input  wire logic [7:0]        dq_in,
    output logic [7:0]             dq_out,
    output logic                   dq_oe,
    output logic                   ce_n,
    output logic                   oe_n,
    output logic                   program_strobe_low,
    output logic                   id_high_voltage,
    // supply controls: high selects 6.5 V core / 13.0 V program, low selects 5.0 V
    output logic                   vcc_high,
    output logic                   vpp_high
);
    localparam int SETUP_CYC  = (`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int TOE_CYC    = (`TOE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int VERIFY_OUTPUT_FLOAT_DELAY_CYC   = (`VERIFY_OUTPUT_FLOAT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    // bounds scale with the pulse length, so a shortened pulse is still held to its tolerance
    localparam int PW_MIN_CYC = (PULSE_CYCLES * `PW_MIN_NS + `PW_NOM_NS - 1) / `PW_NOM_NS;
    localparam int PW_MAX_CYC = PULSE_CYCLES * `PW_MAX_NS / `PW_NOM_NS;
    localparam logic [3:0] RETRY_MAX = 4'(`RETRY_LIMIT);

    otp_prog_pkg::seq_state_t state;
    otp_prog_pkg::seq_state_t prev_state;
    logic                     timer_load;
    logic                     expired;
    logic                     adv;
    logic                     last;
    logic                     match;
    logic [7:0]               rd_byte;
    logic [3:0]               retry;
    logic                     aborted;
    logic                     final_bad;

    // state durations; strobe and setup states absorb the two-cycle timer overhead
    function automatic logic [`TIMER_W-1:0] wait_of(input otp_prog_pkg::seq_state_t s);
        logic [`TIMER_W-1:0] w;
        w = `TIMER_W'(SETUP_CYC - `SEQ_OVH);
        if (s == otp_prog_pkg::ST_P_PULSE || s == otp_prog_pkg::ST_V_PULSE)
            w = `TIMER_W'(PULSE_CYCLES - `SEQ_OVH);
        else if (is_read(s))
            w = `TIMER_W'(TOE_CYC);
        else if (s == otp_prog_pkg::ST_V_FLOAT || s == otp_prog_pkg::ST_F_FLOAT
                 || s == otp_prog_pkg::ST_ID_FLOAT)
            w = `TIMER_W'(VERIFY_OUTPUT_FLOAT_DELAY_CYC);
        return w;
    endfunction

    function automatic logic is_read(input otp_prog_pkg::seq_state_t s);
        return s == otp_prog_pkg::ST_V_READ || s == otp_prog_pkg::ST_F_READ
            || s == otp_prog_pkg::ST_ID_READ;
    endfunction

    function automatic logic is_prog(input otp_prog_pkg::seq_state_t s);
        return s == otp_prog_pkg::ST_P_SETUP || s == otp_prog_pkg::ST_P_PULSE
            || s == otp_prog_pkg::ST_P_HOLD || s == otp_prog_pkg::ST_V_SETUP
            || s == otp_prog_pkg::ST_V_PULSE || s == otp_prog_pkg::ST_V_HOLD;
    endfunction

    wait_timer #(.W(`TIMER_W)) u_timer (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .load       (timer_load),
        .load_value (wait_of(state)),
        .expired    (expired)
    );

    // the timer still shows the old expiry in a state's first cycle
    assign timer_load = (state != prev_state);
    assign adv        = !timer_load && expired;
    assign last       = &rom_addr;
    assign match      = (rd_byte == src_data);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            prev_state <= otp_prog_pkg::ST_IDLE;
        else
            prev_state <= state;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            state <= otp_prog_pkg::ST_IDLE;
        else
        begin
            unique case (state)
                otp_prog_pkg::ST_IDLE:
                    if (start)
                        state <= otp_prog_pkg::ST_VCC_UP;
                    else if (id_start)
                        state <= otp_prog_pkg::ST_ID_ENTER;
                otp_prog_pkg::ST_VCC_UP:
                    if (adv) state <= otp_prog_pkg::ST_VPP_UP;
                otp_prog_pkg::ST_VPP_UP:
                    if (adv) state <= otp_prog_pkg::ST_P_SETUP;
                otp_prog_pkg::ST_P_SETUP:
                    if (adv) state <= otp_prog_pkg::ST_P_PULSE;
                otp_prog_pkg::ST_P_PULSE:
                    if (adv) state <= otp_prog_pkg::ST_P_HOLD;
                otp_prog_pkg::ST_P_HOLD:
                    if (adv) state <= last ? otp_prog_pkg::ST_V_READ
                                           : otp_prog_pkg::ST_P_SETUP;
                otp_prog_pkg::ST_V_READ:
                    if (adv) state <= otp_prog_pkg::ST_V_FLOAT;
                otp_prog_pkg::ST_V_FLOAT:
                    if (adv)
                    begin
                        if (match)
                            state <= last ? otp_prog_pkg::ST_VPP_DN
                                          : otp_prog_pkg::ST_V_READ;
                        else if (retry == RETRY_MAX)
                            state <= otp_prog_pkg::ST_VPP_DN;
                        else
                            state <= otp_prog_pkg::ST_V_SETUP;
                    end
                otp_prog_pkg::ST_V_SETUP:
                    if (adv) state <= otp_prog_pkg::ST_V_PULSE;
                otp_prog_pkg::ST_V_PULSE:
                    if (adv) state <= otp_prog_pkg::ST_V_HOLD;
                otp_prog_pkg::ST_V_HOLD:
                    if (adv) state <= otp_prog_pkg::ST_V_READ;
                otp_prog_pkg::ST_VPP_DN:
                    if (adv) state <= otp_prog_pkg::ST_VCC_DN;
                otp_prog_pkg::ST_VCC_DN:
                    if (adv) state <= aborted ? otp_prog_pkg::ST_FINISH
                                              : otp_prog_pkg::ST_F_READ;
                otp_prog_pkg::ST_F_READ:
                    if (adv) state <= otp_prog_pkg::ST_F_FLOAT;
                otp_prog_pkg::ST_F_FLOAT:
                    if (adv) state <= last ? otp_prog_pkg::ST_FINISH
                                           : otp_prog_pkg::ST_F_READ;
                otp_prog_pkg::ST_FINISH:
                    state <= otp_prog_pkg::ST_IDLE;
                otp_prog_pkg::ST_ID_ENTER:
                    if (adv) state <= otp_prog_pkg::ST_ID_READ;
                otp_prog_pkg::ST_ID_READ:
                    if (adv) state <= otp_prog_pkg::ST_ID_FLOAT;
                otp_prog_pkg::ST_ID_FLOAT:
                    if (adv) state <= otp_prog_pkg::ST_IDLE;
                default:
                    state <= otp_prog_pkg::ST_IDLE;
            endcase
        end
    end

    // address walk
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            rom_addr <= '0;
        else if (state == otp_prog_pkg::ST_IDLE && start)
            rom_addr <= '0;
        else if (state == otp_prog_pkg::ST_IDLE && id_start)
            rom_addr <= ADDR_W'(id_sel);
        else if (adv && !last && (state == otp_prog_pkg::ST_P_HOLD
                 || state == otp_prog_pkg::ST_F_FLOAT
                 || (state == otp_prog_pkg::ST_V_FLOAT && match)))
            rom_addr <= rom_addr + ADDR_W'(1);
        else if (adv && (state == otp_prog_pkg::ST_P_HOLD || state == otp_prog_pkg::ST_VCC_DN))
            rom_addr <= '0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            retry <= '0;
        else if (state == otp_prog_pkg::ST_V_FLOAT && adv && match)
            retry <= '0;
        else if (state == otp_prog_pkg::ST_V_PULSE && adv)
            retry <= retry + 4'(1);
        else if (state == otp_prog_pkg::ST_IDLE)
            retry <= '0;
    end

    // data sampled at the end of the read wait, while oe is still low
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            rd_byte <= '0;
        else if (is_read(state) && adv)
            rd_byte <= dq_in;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            aborted   <= 1'b0;
            final_bad <= 1'b0;
            fail_addr <= '0;
        end
        else if (state == otp_prog_pkg::ST_IDLE && start)
        begin
            aborted   <= 1'b0;
            final_bad <= 1'b0;
        end
        else if (state == otp_prog_pkg::ST_V_FLOAT && adv && !match && retry == RETRY_MAX)
        begin
            aborted   <= 1'b1;
            fail_addr <= rom_addr;
        end
        else if (state == otp_prog_pkg::ST_F_FLOAT && adv && !match)
        begin
            final_bad <= 1'b1;
            fail_addr <= rom_addr;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            done <= 1'b0;
            pass <= 1'b0;
            fail <= 1'b0;
        end
        else
        begin
            done <= (state == otp_prog_pkg::ST_FINISH);
            if (state == otp_prog_pkg::ST_IDLE && start)
            begin
                pass <= 1'b0;
                fail <= 1'b0;
            end
            else if (state == otp_prog_pkg::ST_FINISH)
            begin
                pass <= !aborted && !final_bad;
                fail <= aborted || final_bad;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            id_code  <= '0;
            id_valid <= 1'b0;
        end
        else
        begin
            id_valid <= (state == otp_prog_pkg::ST_ID_FLOAT && adv);
            if (state == otp_prog_pkg::ST_ID_FLOAT && adv)
                id_code <= rd_byte;
        end
    end

    // pin drive follows the state one cycle later, so every width equals the state time
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            busy               <= 1'b0;
            ce_n               <= 1'b1;
            oe_n               <= 1'b1;
            program_strobe_low <= 1'b1;
            dq_oe              <= 1'b0;
            dq_out             <= '0;
            id_high_voltage    <= 1'b0;
            vcc_high           <= 1'b0;
            vpp_high           <= 1'b0;
        end
        else
        begin
            busy   <= (state != otp_prog_pkg::ST_IDLE);
            ce_n   <= !(is_prog(state) || is_read(state)
                        || state == otp_prog_pkg::ST_V_FLOAT);
            oe_n   <= !is_read(state);
            program_strobe_low <= !(state == otp_prog_pkg::ST_P_PULSE
                                    || state == otp_prog_pkg::ST_V_PULSE);
            dq_oe  <= is_prog(state);
            dq_out <= src_data;
            id_high_voltage <= (state == otp_prog_pkg::ST_ID_ENTER
                                || state == otp_prog_pkg::ST_ID_READ
                                || state == otp_prog_pkg::ST_ID_FLOAT);
            vcc_high <= (state == otp_prog_pkg::ST_VCC_UP || state == otp_prog_pkg::ST_VPP_UP
                         || is_prog(state) || state == otp_prog_pkg::ST_V_READ
                         || state == otp_prog_pkg::ST_V_FLOAT
                         || state == otp_prog_pkg::ST_VPP_DN);
            vpp_high <= (state == otp_prog_pkg::ST_VPP_UP || is_prog(state)
                         || state == otp_prog_pkg::ST_V_READ
                         || state == otp_prog_pkg::ST_V_FLOAT);
        end
    end

    // helper counters watched only by the checks below
    logic [`TIMER_W-1:0] low_cnt;
    logic [`TIMER_W-1:0] oe_low_cnt;
    logic [`TIMER_W-1:0] oe_high_cnt;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            low_cnt     <= '0;
            oe_low_cnt  <= '0;
            oe_high_cnt <= '0;
        end
        else
        begin
            low_cnt     <= program_strobe_low ? '0 : low_cnt + `TIMER_W'(1);
            oe_low_cnt  <= oe_n ? '0 : oe_low_cnt + `TIMER_W'(1);
            oe_high_cnt <= !oe_n ? '0 : ((&oe_high_cnt) ? oe_high_cnt
                                                        : oe_high_cnt + `TIMER_W'(1));
        end
    end

    property p_pulse_width;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(program_strobe_low) |-> low_cnt >= PW_MIN_CYC && low_cnt <= PW_MAX_CYC;
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("program pulse width out of range");

    property p_supply_order;
        @(posedge clk_sys) disable iff (!rst_n)
        vpp_high |-> vcc_high;
    endproperty
    a_supply_order: assert property (p_supply_order)
        else $error("programming supply high without core supply");

    property p_pulse_conditions;
        @(posedge clk_sys) disable iff (!rst_n)
        !program_strobe_low |-> vcc_high && vpp_high && !ce_n && oe_n && dq_oe;
    endproperty
    a_pulse_conditions: assert property (p_pulse_conditions)
        else $error("program pulse without supplies, select or data");

    property p_first_addr;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(vpp_high) |-> rom_addr == '0 ##1 program_strobe_low [*3];
    endproperty
    a_first_addr: assert property (p_first_addr)
        else $error("programming did not start at the first address");

    property p_read_wait;
        @(posedge clk_sys) disable iff (!rst_n)
        (is_read(state) && adv) |-> !oe_n && oe_low_cnt >= TOE_CYC;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read data sampled before valid delay");

    property p_float_wait;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(dq_oe) |-> oe_high_cnt > VERIFY_OUTPUT_FLOAT_DELAY_CYC;
    endproperty
    a_float_wait: assert property (p_float_wait)
        else $error("data driven before rom output floated");

    property p_retry_limit;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(aborted) |-> $past(retry) == RETRY_MAX && !$past(match);
    endproperty
    a_retry_limit: assert property (p_retry_limit)
        else $error("abort not at the retry limit");

    property p_done_supplies;
        @(posedge clk_sys) disable iff (!rst_n)
        done |-> !vcc_high && !vpp_high && (pass != fail);
    endproperty
    a_done_supplies: assert property (p_done_supplies)
        else $error("finished with raised supply or bad verdict");

    property p_pass_clean;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(pass) |-> !$past(aborted) && !$past(final_bad);
    endproperty
    a_pass_clean: assert property (p_pass_clean)
        else $error("pass given after a mismatch");

    property p_id_voltage;
        @(posedge clk_sys) disable iff (!rst_n)
        id_valid |-> id_high_voltage && !vpp_high && rom_addr[0] == $past(rom_addr[0], 4);
    endproperty
    a_id_voltage: assert property (p_id_voltage)
        else $error("id code read without id voltage");
endmodule

// ---- otp_prog_regs.svh ----
// timing, retry and address constants for the otp programming sequencer
// assumes a 125 MHz system clock; all times are in nanoseconds
`ifndef OTP_PROG_REGS_SVH
`define OTP_PROG_REGS_SVH

`define CLK_PERIOD_NS  8
`define PW_NOM_NS      100000
`define PW_MIN_NS      95000
`define PW_MAX_NS      105000
`define SETUP_NS       2000
`define TOE_NS         150
`define VERIFY_OUTPUT_FLOAT_DELAY_NS        130
`define RETRY_LIMIT    10
`define ADDR_W         17
`define SEQ_OVH        2
`define TIMER_W        16

`endif

// ---- otp_prog_pkg.sv ----
// types shared by the otp programming sequencer
// no assumptions beyond a single clock domain
package otp_prog_pkg;

    typedef enum logic [4:0]
    {
        ST_IDLE,
        ST_VCC_UP,
        ST_VPP_UP,
        ST_P_SETUP,
        ST_P_PULSE,
        ST_P_HOLD,
        ST_V_READ,
        ST_V_FLOAT,
        ST_V_SETUP,
        ST_V_PULSE,
        ST_V_HOLD,
        ST_VPP_DN,
        ST_VCC_DN,
        ST_F_READ,
        ST_F_FLOAT,
        ST_FINISH,
        ST_ID_ENTER,
        ST_ID_READ,
        ST_ID_FLOAT
    } seq_state_t;

endpackage

// ---- wait_timer.sv ----
// down-counting wait timer for the sequencer
// load is a one-cycle pulse; expired rises load_value edges after it
`timescale 1ns/10ps
module wait_timer #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    output logic              expired
);
    logic [W-1:0] count;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            count <= '0;
        else if (load)
            count <= load_value;
        else if (count != '0)
            count <= count - W'(1);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            expired <= 1'b1;
        else
            expired <= !load && (count <= W'(1));
    end
endmodule

// ---- otp_rom_model.sv ----
// behavioural byte-wide otp rom answering at its pins
// assumes pins change just after clk_sys edges; erase blanks the array to all ones
`timescale 1ns/10ps
module otp_rom_model #(
    parameter int       AW       = 3,
    parameter int       PW       = 20,
    parameter int       DLY      = 18,
    parameter bit [7:0] MAKER_ID = 8'h5a,   // arbitrary value
    parameter bit [7:0] TYPE_ID  = 8'ha7    // arbitrary value
) (
    // clock and test control
    input  wire logic          clk_sys,
    input  wire logic          erase,
    input  wire logic [AW-1:0] weak_addr,
    input  wire logic [7:0]    weak_need,
    // rom pins
    input  wire logic [AW-1:0] rom_addr,
    input  wire logic [7:0]    dq_out,
    input  wire logic          dq_oe,
    input  wire logic          ce_n,
    input  wire logic          oe_n,
    input  wire logic          program_strobe_low,
    input  wire logic          id_high_voltage,
    input  wire logic          vcc_high,
    input  wire logic          vpp_high,
    output logic [7:0]         dq_in
);
    logic [7:0] mem [2**AW];
    logic [7:0] word;
    int         pulses [2**AW];
    int         n_bad, first_addr, low_cnt, oe_cnt;

    initial dq_in = 8'h00;
    assign word = id_high_voltage ? (rom_addr[0] ? TYPE_ID : MAKER_ID) : mem[rom_addr];

    always @(posedge clk_sys)
    begin
        if (erase)
        begin
            foreach (mem[i])
            begin
                mem[i] = 8'hff;
                pulses[i] = 0;
            end
            n_bad = 0;
            first_addr = -1;
            low_cnt = 0;
            oe_cnt = 0;
        end
        else
        begin
            // late data, then a moving pattern once released: no held value to lean on
            dq_in <= (!ce_n && !oe_n && oe_cnt >= DLY) ? word : ~dq_in;
            oe_cnt = (!ce_n && !oe_n) ? oe_cnt + 1 : 0;
            if (!ce_n && !oe_n && dq_oe)
                n_bad++;
            if (vpp_high && !vcc_high)
                n_bad++;
            if (!program_strobe_low)
                low_cnt++;
            else if (low_cnt != 0)
            begin
                if (low_cnt != PW || ce_n || !dq_oe || !vcc_high || !vpp_high)
                    n_bad++;
                if (first_addr < 0)
                    first_addr = rom_addr;
                pulses[rom_addr]++;
                // a weak cell takes weak_need pulses before its bits fall
                if (rom_addr != weak_addr || pulses[rom_addr] >= weak_need)
                    mem[rom_addr] &= dq_out;
                low_cnt = 0;
            end
        end
    end
endmodule

// ---- otp_rom_program_sequencer_test.sv ----
// self-checking bench for the otp programming sequencer against a rom model
// assumes short pulse and a 3-bit array so that whole runs stay brief
`timescale 1ns/10ps
module otp_rom_program_sequencer_test;
    localparam int       AW    = 3;
    localparam int       PW    = 20;
    localparam bit [7:0] MAKER = 8'h5a;
    localparam bit [7:0] TYPE  = 8'ha7;
    logic          clk_sys, rst_n, start, id_start, id_sel, erase, busy, done, pass, fail;
    logic          id_valid, dq_oe, ce_n, oe_n, program_strobe_low, id_high_voltage;
    logic          vcc_high, vpp_high;
    logic [AW-1:0] fail_addr, rom_addr, weak_addr;
    logic [7:0]    src_data, id_code, dq_in, dq_out, weak_need;
    logic [7:0]    img [2**AW];
    int            n_mismatch, cmp_count, cyc;

    assign src_data = img[rom_addr];

    otp_rom_program_sequencer #(.PULSE_CYCLES(PW), .ADDR_W(AW)) otp_rom_program_sequencer_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .start(start), .id_start(id_start), .id_sel(id_sel),
        .src_data(src_data), .busy(busy), .done(done), .pass(pass), .fail(fail),
        .fail_addr(fail_addr), .id_code(id_code), .id_valid(id_valid), .rom_addr(rom_addr),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n),
        .program_strobe_low(program_strobe_low), .id_high_voltage(id_high_voltage),
        .vcc_high(vcc_high), .vpp_high(vpp_high));

    otp_rom_model #(.AW(AW), .PW(PW), .MAKER_ID(MAKER), .TYPE_ID(TYPE)) otp_rom_model_i (
        .clk_sys(clk_sys), .erase(erase), .weak_addr(weak_addr), .weak_need(weak_need),
        .rom_addr(rom_addr), .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n),
        .program_strobe_low(program_strobe_low), .id_high_voltage(id_high_voltage),
        .vcc_high(vcc_high), .vpp_high(vpp_high), .dq_in(dq_in));

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask

    // polls just after each edge so one-cycle pulses are never missed
    task automatic wait_for(input bit want_id);
        int k;
        k = 0;
        do
        begin
            step();
            k++;
        end
        while (!((want_id ? id_valid : done) === 1'b1) && k < 30000);
        if (k >= 30000)
            n_mismatch++;
    endtask

    task automatic run_prog(input logic [AW-1:0] wa, input logic [7:0] need,
                            input logic want_pass, input int want_pulses);
        erase = 1'b1;
        weak_addr = wa;
        weak_need = need;
        step();
        erase = 1'b0;
        start = 1'b1;
        step();
        start = 1'b0;
        step();
        step();
        check("busy and supplies", 17'(3'b110), 17'({busy, vcc_high, vpp_high}));
        wait_for(1'b0);
        check("pass", 17'(want_pass), 17'(pass));
        check("fail", 17'(!want_pass), 17'(fail));
        check("pin faults", 17'(0), 17'(otp_rom_model_i.n_bad));
        check("first address", 17'(0), 17'(otp_rom_model_i.first_addr));
        if (!want_pass)
            check("fail_addr", 17'(wa), 17'(fail_addr));
        for (int i = 0; i < 2**AW; i++)
        begin
            check("pulses", 17'(i == wa ? want_pulses : 1), 17'(otp_rom_model_i.pulses[i]));
            if (want_pass)
                check("byte", 17'(img[i]), 17'(otp_rom_model_i.mem[i]));
        end
        step();
        check("supplies", 17'(0), 17'({vcc_high, vpp_high}));
    endtask

    task automatic read_id(input logic sel, input logic [7:0] exp);
        id_sel = sel;
        id_start = 1'b1;
        step();
        id_start = 1'b0;
        wait_for(1'b1);
        check("id_code", 17'(exp), 17'(id_code));
    endtask

    initial
    begin
        rst_n = 1'b0;
        start = 1'b0;
        id_start = 1'b0;
        id_sel = 1'b0;
        erase = 1'b1;
        weak_addr = '0;
        weak_need = 8'h01;
        for (int i = 0; i < 2**AW; i++)
            img[i] = 8'hc3 ^ 8'(i * 37);
        repeat (6) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        run_prog(3'h5, 8'h01, 1'b1, 1);
        run_prog(3'h2, 8'h04, 1'b1, 4);
        run_prog(3'h7, 8'h0b, 1'b1, 11);
        run_prog(3'h3, 8'h0c, 1'b0, 11);
        read_id(1'b0, MAKER);
        read_id(1'b1, TYPE);
        report_and_stop();
    end
endmodule
